// [core/dsc_pkg.sv]
package dsc_pkg;

    // widths and counts
    localparam int DSC_SF_W           = 8;
    localparam int DSC_CNT_W          = 11;
    localparam int DSC_FILT_W         = 36;
    localparam int DSC_ADDR_W         = 8;
    localparam int DSC_DATA_W         = 32;
    localparam int DSC_DEC_SHIFT      = 3;
    localparam int DSC_PHASES         = 3;
    localparam int DSC_SETTLE_OUTPUTS = 2;

    // decimation word limits and reset value
    localparam logic [7:0] DSC_SF_RESET = 8'h45;
    localparam logic [7:0] DSC_SF_MIN   = 8'h0D;
    localparam logic [7:0] DSC_SF_MAX   = 8'hFF;

    // register offsets (byte addresses)
    localparam logic [7:0] DSC_OFF_DEC      = 8'h00;
    localparam logic [7:0] DSC_OFF_MAIN_CFG = 8'h04;
    localparam logic [7:0] DSC_OFF_AUX_CTL  = 8'h08;
    localparam logic [7:0] DSC_OFF_STATUS   = 8'h0C;
    localparam logic [7:0] DSC_OFF_MAIN_LO  = 8'h10;
    localparam logic [7:0] DSC_OFF_MAIN_HI  = 8'h14;
    localparam logic [7:0] DSC_OFF_AUX_LO   = 8'h18;
    localparam logic [7:0] DSC_OFF_AUX_HI   = 8'h1C;

    // main configuration fields
    localparam int DSC_MCFG_RANGE_LSB = 0;
    localparam int DSC_MCFG_MUX_LSB   = 4;
    localparam int DSC_MCFG_BUF_BIT   = 8;
    localparam int DSC_MCFG_BURN_BIT  = 9;
    // aux control fields
    localparam int DSC_ACTL_RANGE_BIT = 0;
    localparam int DSC_ACTL_MUX_LSB   = 4;
    // status fields
    localparam int DSC_ST_MAIN_RDY    = 0;
    localparam int DSC_ST_AUX_RDY     = 1;
    localparam int DSC_ST_MAIN_SETTLD = 2;
    localparam int DSC_ST_AUX_SETTLD  = 3;
    localparam int DSC_ST_MAIN_CHOP   = 4;
    localparam int DSC_ST_AUX_CHOP    = 5;

    // main multiplexer codes
    localparam logic [2:0] DSC_MMUX_DIFF_12   = 3'h0;
    localparam logic [2:0] DSC_MMUX_DIFF_34   = 3'h1;
    localparam logic [2:0] DSC_MMUX_PSEUDO_14 = 3'h2;
    localparam logic [2:0] DSC_MMUX_PSEUDO_24 = 3'h3;
    localparam logic [2:0] DSC_MMUX_PSEUDO_34 = 3'h4;
    // aux multiplexer codes
    localparam logic [1:0] DSC_AMUX_SE_3   = 2'h0;
    localparam logic [1:0] DSC_AMUX_SE_4   = 2'h1;
    localparam logic [1:0] DSC_AMUX_DIFF56 = 2'h2;
    localparam logic [1:0] DSC_AMUX_SE_5   = 2'h3;

    // reset values of configuration fields
    localparam logic [2:0] DSC_RANGE_RESET    = 3'h0;
    localparam logic [2:0] DSC_MMUX_RESET     = DSC_MMUX_DIFF_12;
    localparam logic [1:0] DSC_AMUX_RESET     = DSC_AMUX_SE_3;
    localparam logic       DSC_BUF_RESET      = 1'b1;
    localparam logic       DSC_BURN_RESET     = 1'b0;
    localparam logic       DSC_AUX_RNG_RESET  = 1'b0;

endpackage

// [core/dsc_sinc3.sv]
`timescale 1ns/1ps
module dsc_sinc3
    import dsc_pkg::*;
#(
    parameter int W  = DSC_FILT_W,
    parameter int CW = DSC_CNT_W
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // control
    input  wire logic          restart,
    input  wire logic [CW-1:0] dec_len,
    // modulator samples
    input  wire logic          sample_en,
    input  wire logic          sample_bit,
    // decimated output
    output logic               out_valid,
    output logic [W-1:0]       out_data
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [W-1:0]  i1;
        logic [W-1:0]  i2;
        logic [W-1:0]  i3;
        logic [W-1:0]  d1;
        logic [W-1:0]  d2;
        logic [W-1:0]  d3;
        logic [W-1:0]  out;
        logic          valid;
    } dsc_sinc_t;

    dsc_sinc_t s;
    dsc_sinc_t next_s;
    logic [W-1:0] c1;
    logic [W-1:0] c2;

    always_comb begin
        next_s = s;
        next_s.valid = 1'b0;
        // chained integrators so a comb window holds exactly the newest 8*word samples
        c1 = s.i3 + s.i2 + s.i1 + W'(sample_bit) - s.d1;
        c2 = c1 - s.d2;
        if (restart) begin
            next_s = '0;
        end else if (sample_en) begin
            // three integrators at modulator rate
            next_s.i1 = s.i1 + W'(sample_bit);
            next_s.i2 = s.i2 + next_s.i1;
            next_s.i3 = s.i3 + next_s.i2;
            if (s.cnt == CW'(dec_len - 1'b1)) begin
                // three combs at the decimated rate
                next_s.cnt = '0;
                next_s.d1 = next_s.i3;
                next_s.d2 = c1;
                next_s.d3 = c2;
                next_s.out = c2 - s.d3;
                next_s.valid = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid = s.valid;
    assign out_data  = s.out;

endmodule

// [core/dsc_chop_avg.sv]
`timescale 1ns/1ps
module dsc_chop_avg
    import dsc_pkg::*;
#(
    parameter int W = DSC_FILT_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         restart,
    // sinc3 side
    input  wire logic         filt_valid,
    input  wire logic [W-1:0] filt_data,
    // chop phase and averaged result
    output logic              chop,
    output logic              res_valid,
    output logic [W-1:0]      res_data,
    output logic              settled
);

    typedef struct packed {
        logic [1:0]   phase;
        logic         chop;
        logic [W-1:0] prev;
        logic [W-1:0] res;
        logic         valid;
        logic [1:0]   settle_cnt;
    } dsc_avg_t;

    dsc_avg_t s;
    dsc_avg_t next_s;
    logic [W:0] sum;

    always_comb begin
        next_s = s;
        next_s.valid = 1'b0;
        sum = {1'b0, filt_data} + {1'b0, s.prev};
        if (restart) begin
            next_s = '0;
        end else if (filt_valid) begin
            // only the third decimation after a chop edge is fully one phase
            if (s.phase == 2'(DSC_PHASES - 1)) begin
                next_s.phase = '0;
                next_s.res = sum[W:1];
                next_s.valid = 1'b1;
                next_s.prev = filt_data;
                next_s.chop = ~s.chop;
                if (s.settle_cnt != 2'(DSC_SETTLE_OUTPUTS)) begin
                    next_s.settle_cnt = s.settle_cnt + 1'b1;
                end
            end else begin
                next_s.phase = s.phase + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign chop      = s.chop;
    assign res_valid = s.valid;
    assign res_data  = s.res;
    assign settled   = (s.settle_cnt == 2'(DSC_SETTLE_OUTPUTS));

endmodule

// [core/dsc_top.sv]
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - sinc3 decimation ratio is word times eight
// - result rate is modulator rate over 24*word
// - one decimation word serves both channels
// - chop phase toggles once per three filter outputs
// - input chop via mux, output chop by XOR
// - result is average of the last outputs of two chop phases
// - settled flag only after two results post-change
// - decimation word 13..255, resets to 69
// - sinc3 and averaging notches follow from structure
// - 3 dB bandwidth 0.24 of update rate
// - main channel selects one of eight ranges
// - main mux: two differential or three pseudo-differential
// - main channel buffered or unbuffered select
// - burnout currents switch independently of conversions
// - aux range select picks full or half reference
// - aux mux: inputs 3, 4, 5/6 or 5
// - aux path identical to main, no gain
// - decimation word fills bits seven to zero
module dsc_top
    import dsc_pkg::*;
#(
    parameter int FILT_W = DSC_FILT_W
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // modulator bitstreams and their clock
    input  wire logic                  mod_clk,
    input  wire logic                  main_mod_bit,
    input  wire logic                  aux_mod_bit,
    // register port
    input  wire logic [DSC_ADDR_W-1:0] addr,
    input  wire logic [DSC_DATA_W-1:0] wr_data,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [DSC_DATA_W-1:0] rd_data,
    // main front-end controls
    output logic      [2:0]            main_range,
    output logic      [2:0]            main_mux_sel,
    output logic                       main_buffered,
    output logic                       burnout_en,
    output logic                       main_input_chop,
    // aux front-end controls
    output logic                       aux_range_select,
    output logic      [1:0]            aux_mux_sel,
    output logic                       aux_input_chop
);

    typedef struct packed {
        logic                  mclk_s1;
        logic                  mclk_s2;
        logic                  mclk_s3;
        logic                  mbit_s1;
        logic                  mbit_s2;
        logic                  abit_s1;
        logic                  abit_s2;
        logic [DSC_SF_W-1:0]   decimation_word;
        logic [2:0]            main_range;
        logic [2:0]            main_mux_sel;
        logic                  main_buffered;
        logic                  burnout_en;
        logic                  aux_range_select;
        logic [1:0]            aux_mux_sel;
        logic [FILT_W-1:0]     main_data;
        logic [FILT_W-1:0]     aux_data;
        logic [DSC_DATA_W-1:0] main_hi_shadow;
        logic [DSC_DATA_W-1:0] aux_hi_shadow;
        logic                  main_rdy;
        logic                  aux_rdy;
        logic                  restart;
        logic [DSC_DATA_W-1:0] rd_data;
    } dsc_top_t;

    dsc_top_t s;
    dsc_top_t next_s;

    logic                  sample_en;
    logic                  main_chop;
    logic                  aux_chop;
    logic                  main_filt_valid;
    logic                  aux_filt_valid;
    logic [FILT_W-1:0]     main_filt;
    logic [FILT_W-1:0]     aux_filt;
    logic                  main_res_valid;
    logic                  aux_res_valid;
    logic [FILT_W-1:0]     main_res;
    logic [FILT_W-1:0]     aux_res;
    logic                  main_settled;
    logic                  aux_settled;
    logic [DSC_CNT_W-1:0]  dec_len;

    function automatic logic [DSC_DATA_W-1:0] lo_word(input logic [FILT_W-1:0] d);
        lo_word = d[DSC_DATA_W-1:0];
    endfunction

    function automatic logic [DSC_DATA_W-1:0] hi_word(input logic [FILT_W-1:0] d);
        hi_word = DSC_DATA_W'(d >> DSC_DATA_W);
    endfunction

    function automatic logic [DSC_SF_W-1:0] clamp_sf(input logic [DSC_SF_W-1:0] v);
        clamp_sf = (v < DSC_SF_MIN) ? DSC_SF_MIN : v;
    endfunction

    // one rising modulator clock edge, seen after synchronising
    assign sample_en = s.mclk_s2 & ~s.mclk_s3;

    // shared ratio for both channels
    assign dec_len = DSC_CNT_W'({s.decimation_word, 3'h0});

    // main path: output chop, sinc3, chop averaging
    dsc_sinc3 #(
        .W  (FILT_W),
        .CW (DSC_CNT_W)
    ) u_main_sinc (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .restart    (s.restart),
        .dec_len    (dec_len),
        .sample_en  (sample_en),
        .sample_bit (s.mbit_s2 ^ main_chop),
        .out_valid  (main_filt_valid),
        .out_data   (main_filt)
    );

    dsc_chop_avg #(
        .W (FILT_W)
    ) u_main_avg (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .restart    (s.restart),
        .filt_valid (main_filt_valid),
        .filt_data  (main_filt),
        .chop       (main_chop),
        .res_valid  (main_res_valid),
        .res_data   (main_res),
        .settled    (main_settled)
    );

    // aux path is the same chain without gain
    dsc_sinc3 #(
        .W  (FILT_W),
        .CW (DSC_CNT_W)
    ) u_aux_sinc (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .restart    (s.restart),
        .dec_len    (dec_len),
        .sample_en  (sample_en),
        .sample_bit (s.abit_s2 ^ aux_chop),
        .out_valid  (aux_filt_valid),
        .out_data   (aux_filt)
    );

    dsc_chop_avg #(
        .W (FILT_W)
    ) u_aux_avg (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .restart    (s.restart),
        .filt_valid (aux_filt_valid),
        .filt_data  (aux_filt),
        .chop       (aux_chop),
        .res_valid  (aux_res_valid),
        .res_data   (aux_res),
        .settled    (aux_settled)
    );

    always_comb begin
        next_s = s;
        next_s.restart = 1'b0;
        next_s.rd_data = '0;

        // two-flop synchronisers on the modulator pins
        next_s.mclk_s1 = mod_clk;
        next_s.mclk_s2 = s.mclk_s1;
        next_s.mclk_s3 = s.mclk_s2;
        next_s.mbit_s1 = main_mod_bit;
        next_s.mbit_s2 = s.mbit_s1;
        next_s.abit_s1 = aux_mod_bit;
        next_s.abit_s2 = s.abit_s1;

        // register writes; any programming change except burnout restarts both chains
        if (wr_en) begin
            unique case (addr)
                DSC_OFF_DEC: begin
                    next_s.decimation_word = clamp_sf(wr_data[DSC_SF_W-1:0]);
                    next_s.restart = 1'b1;
                end
                DSC_OFF_MAIN_CFG: begin
                    next_s.main_range = wr_data[DSC_MCFG_RANGE_LSB +: 3];
                    next_s.main_mux_sel = wr_data[DSC_MCFG_MUX_LSB +: 3];
                    next_s.main_buffered = wr_data[DSC_MCFG_BUF_BIT];
                    if (wr_data[DSC_MCFG_RANGE_LSB +: 3] != s.main_range
                        || wr_data[DSC_MCFG_MUX_LSB +: 3] != s.main_mux_sel
                        || wr_data[DSC_MCFG_BUF_BIT] != s.main_buffered) begin
                        next_s.restart = 1'b1;
                    end
                    // burnout alone never disturbs conversions
                    next_s.burnout_en = wr_data[DSC_MCFG_BURN_BIT];
                end
                DSC_OFF_AUX_CTL: begin
                    next_s.aux_range_select = wr_data[DSC_ACTL_RANGE_BIT];
                    next_s.aux_mux_sel = wr_data[DSC_ACTL_MUX_LSB +: 2];
                    next_s.restart = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // register reads, data one cycle later
        if (rd_en) begin
            unique case (addr)
                DSC_OFF_DEC: begin
                    next_s.rd_data = DSC_DATA_W'(s.decimation_word);
                end
                DSC_OFF_MAIN_CFG: begin
                    next_s.rd_data[DSC_MCFG_RANGE_LSB +: 3] = s.main_range;
                    next_s.rd_data[DSC_MCFG_MUX_LSB +: 3] = s.main_mux_sel;
                    next_s.rd_data[DSC_MCFG_BUF_BIT] = s.main_buffered;
                    next_s.rd_data[DSC_MCFG_BURN_BIT] = s.burnout_en;
                end
                DSC_OFF_AUX_CTL: begin
                    next_s.rd_data[DSC_ACTL_RANGE_BIT] = s.aux_range_select;
                    next_s.rd_data[DSC_ACTL_MUX_LSB +: 2] = s.aux_mux_sel;
                end
                DSC_OFF_STATUS: begin
                    next_s.rd_data[DSC_ST_MAIN_RDY] = s.main_rdy;
                    next_s.rd_data[DSC_ST_AUX_RDY] = s.aux_rdy;
                    next_s.rd_data[DSC_ST_MAIN_SETTLD] = main_settled;
                    next_s.rd_data[DSC_ST_AUX_SETTLD] = aux_settled;
                    next_s.rd_data[DSC_ST_MAIN_CHOP] = main_chop;
                    next_s.rd_data[DSC_ST_AUX_CHOP] = aux_chop;
                end
                DSC_OFF_MAIN_LO: begin
                    // low read freezes the high half for a coherent pair
                    next_s.rd_data = lo_word(s.main_data);
                    next_s.main_hi_shadow = hi_word(s.main_data);
                    next_s.main_rdy = 1'b0;
                end
                DSC_OFF_MAIN_HI: begin
                    next_s.rd_data = s.main_hi_shadow;
                end
                DSC_OFF_AUX_LO: begin
                    next_s.rd_data = lo_word(s.aux_data);
                    next_s.aux_hi_shadow = hi_word(s.aux_data);
                    next_s.aux_rdy = 1'b0;
                end
                DSC_OFF_AUX_HI: begin
                    next_s.rd_data = s.aux_hi_shadow;
                end
                default: begin
                    next_s.rd_data = '0;
                end
            endcase
        end

        // new results load whole; a new result beats a clearing read
        if (main_res_valid) begin
            next_s.main_data = main_res;
            next_s.main_rdy = 1'b1;
        end
        if (aux_res_valid) begin
            next_s.aux_data = aux_res;
            next_s.aux_rdy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.decimation_word <= DSC_SF_RESET;
            s.main_range <= DSC_RANGE_RESET;
            s.main_mux_sel <= DSC_MMUX_RESET;
            s.main_buffered <= DSC_BUF_RESET;
            s.burnout_en <= DSC_BURN_RESET;
            s.aux_range_select <= DSC_AUX_RNG_RESET;
            s.aux_mux_sel <= DSC_AMUX_RESET;
        end else begin
            s <= next_s;
        end
    end

    // notches and bandwidth follow from the sinc3 and two-point average
    assign rd_data          = s.rd_data;
    assign main_range       = s.main_range;
    assign main_mux_sel     = s.main_mux_sel;
    assign main_buffered    = s.main_buffered;
    assign burnout_en       = s.burnout_en;
    assign main_input_chop  = main_chop;
    assign aux_range_select = s.aux_range_select;
    assign aux_mux_sel      = s.aux_mux_sel;
    assign aux_input_chop   = aux_chop;

endmodule

// [test/dsc_sva.sv]
`timescale 1ns/1ps
module dsc_sva
    import dsc_pkg::*;
(
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    // register port
    input wire logic [DSC_ADDR_W-1:0] addr,
    input wire logic [DSC_DATA_W-1:0] wr_data,
    input wire logic                  wr_en,
    input wire logic                  rd_en,
    input wire logic [DSC_DATA_W-1:0] rd_data,
    // front-end controls
    input wire logic [2:0]            main_range,
    input wire logic [2:0]            main_mux_sel,
    input wire logic                  main_buffered,
    input wire logic                  burnout_en,
    input wire logic                  main_input_chop,
    input wire logic                  aux_range_select,
    input wire logic [1:0]            aux_mux_sel,
    input wire logic                  aux_input_chop
);
    // shortest legal result period: 312 samples of at least 4 cycles
    localparam int MIN_GAP = 1248;

    int   gap;
    logic chop_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap    <= 0;
            chop_q <= 1'b0;
        end else begin
            gap    <= (main_input_chop != chop_q) ? 0 : gap + 1;
            chop_q <= main_input_chop;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_chop_pair: assert property (
        main_input_chop == aux_input_chop) else $error("chop phases differ");
    a_chop_gap: assert property (
        $rose(main_input_chop) |-> gap >= MIN_GAP) else $error("result period too short");
    a_reset_vals: assert property (
        $rose(rst_n) |-> main_buffered && main_range == 3'h0 && !burnout_en
        && aux_mux_sel == 2'h0 && !main_input_chop) else $error("bad reset values");
    a_dec_clamp: assert property (
        rd_en && addr == DSC_OFF_DEC |=> rd_data[31:8] == 24'h00_0000
        && rd_data[7:0] >= 8'h0D) else $error("decimation word out of range");
    a_main_cfg: assert property (
        wr_en && addr == DSC_OFF_MAIN_CFG |=> main_range == $past(wr_data[2:0])
        && main_mux_sel == $past(wr_data[6:4])) else $error("main range or mux wrong");
    a_buf_burn: assert property (
        wr_en && addr == DSC_OFF_MAIN_CFG |=> main_buffered == $past(wr_data[8])
        && burnout_en == $past(wr_data[9])) else $error("buffer or burnout wrong");
    a_aux_ctl: assert property (
        wr_en && addr == DSC_OFF_AUX_CTL |=> aux_range_select == $past(wr_data[0])
        && aux_mux_sel == $past(wr_data[5:4])) else $error("aux control wrong");
    a_chop_restart: assert property (
        wr_en && addr == DSC_OFF_DEC |-> ##[1:4] !main_input_chop && !aux_input_chop)
        else $error("restart did not clear chop");
endmodule

// [test/dsc_mod_model.sv]
`timescale 1ns/1ps
module dsc_mod_model #(
    parameter int HALF_NS = 16
) (
    // modulator pins
    output logic main_mod_bit,
    output logic aux_mod_bit,
    output logic mod_clk,
    // requested densities and sample count
    input  wire logic main_level,
    input  wire logic aux_level,
    output int   samples
);
    // free-running modulator clock, bits change on the falling edge
    initial begin
        mod_clk      = 1'b0;
        main_mod_bit = 1'b0;
        aux_mod_bit  = 1'b0;
        samples      = 0;
        #3;
        forever begin
            #HALF_NS mod_clk = 1'b1;
            samples++;
            #HALF_NS mod_clk = 1'b0;
            main_mod_bit = main_level;
            aux_mod_bit  = aux_level;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
    import dsc_pkg::*;
;
    logic                  ref_clk = 1'b0;
    logic                  rst_n, mod_clk, main_mod_bit, aux_mod_bit, wr_en, rd_en;
    logic [DSC_ADDR_W-1:0] addr;
    logic [DSC_DATA_W-1:0] wr_data, rd_data, d, w, cfg;
    logic [2:0]            main_range, main_mux_sel;
    logic                  main_buffered, burnout_en, main_input_chop, chop_q = 1'b0;
    logic                  aux_range_select, aux_input_chop, main_level, aux_level;
    logic [1:0]            aux_mux_sel;
    logic [15:0]           seed;
    int                    samples, fail_count, num_checks, tog_q[$];

    always #2 ref_clk = ~ref_clk;

    dsc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mod_clk(mod_clk),
        .main_mod_bit(main_mod_bit), .aux_mod_bit(aux_mod_bit), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .main_range(main_range), .main_mux_sel(main_mux_sel),
        .main_buffered(main_buffered), .burnout_en(burnout_en),
        .main_input_chop(main_input_chop), .aux_range_select(aux_range_select),
        .aux_mux_sel(aux_mux_sel), .aux_input_chop(aux_input_chop));
    dsc_mod_model u_mod (.main_mod_bit(main_mod_bit), .aux_mod_bit(aux_mod_bit),
        .mod_clk(mod_clk), .main_level(main_level), .aux_level(aux_level),
        .samples(samples));

    // sample count at every chop change
    always @(posedge ref_clk) begin
        if (main_input_chop !== chop_q)
            tog_q.push_back(samples);
        chop_q <= main_input_chop;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // chop k inverts the stream on odd results; average with previous output
    function automatic longint avg(input logic lvl, input int k, inout longint prev,
                                   input longint full);
        longint s;
        s = ((lvl ^ k[0]) == 1'b1) ? full : 0;
        avg = (s + prev) / 2;
        prev = s;
    endfunction

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        v = rd_data;
    endtask

    task automatic conv(input int word, input logic ml);
        longint full, pm, pa, em;
        int t;
        logic [31:0] st;
        main_level <= ml;
        aux_level  <= !ml;
        repeat (20) @(posedge ref_clk);
        wr(DSC_OFF_DEC, 32'(word));
        repeat (8) @(posedge ref_clk);
        tog_q.delete();
        full = longint'(8 * word) ** 3;
        pm = 0;
        pa = 0;
        for (int k = 0; k < 3; k++) begin
            st = 32'h0;
            for (t = 0; t < 6000 && st[1:0] !== 2'b11; t++)
                rd(DSC_OFF_STATUS, st);
            if (t == 6000) begin
                fail_count++;
                conclude();
            end
            `CHK(st[3:2], (k > 0) ? 2'b11 : 2'b00)
            `CHK(st[5:4], (k % 2 == 0) ? 2'b11 : 2'b00)
            `CHK(main_input_chop, st[4])
            em = avg(ml, k, pm, full);
            rd(DSC_OFF_MAIN_LO, d);
            `CHK(d, 32'(em))
            rd(DSC_OFF_MAIN_HI, d);
            `CHK(d, 32'(em >> 32))
            em = avg(!ml, k, pa, full);
            rd(DSC_OFF_AUX_LO, d);
            `CHK(d, 32'(em))
            rd(DSC_OFF_AUX_HI, d);
            `CHK(d, 32'(em >> 32))
            // burnout alone must not restart the filters
            if (k == 1)
                wr(DSC_OFF_MAIN_CFG, cfg ^ 32'h0000_0200);
        end
        `CHK(32'(tog_q.size()), 32'd3)
        if (tog_q.size() >= 3) begin
            `CHK(32'(tog_q[1] - tog_q[0]), 32'(24 * word))
            `CHK(32'(tog_q[2] - tog_q[1]), 32'(24 * word))
        end
        $display("test conversion word %0d done", word);
    endtask

    initial begin
        rst_n      = 1'b0;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        addr       = '0;
        wr_data    = '0;
        main_level = 1'b1;
        aux_level  = 1'b0;
        cfg        = '0;
        seed       = 16'h002A;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(DSC_OFF_DEC, d);
        `CHK(d, 32'h0000_0045)
        wr(DSC_OFF_DEC, 32'h0000_0005);
        rd(DSC_OFF_DEC, d);
        `CHK(d, 32'h0000_000D)
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 32'h0000_00FF : (i == 1) ? 32'h0000_0045 :
                (i == 2) ? 32'h0000_0052 : 32'h0000_0044;
            wr(DSC_OFF_DEC, w);
            rd(DSC_OFF_DEC, d);
            `CHK(d, w)
        end
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, d);
        `CHK(d, 32'h0000_0000)
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            cfg = {22'h0, seed[9:8], 1'b0, 3'(seed[6:4] % 5), 1'b0, seed[2:0]};
            wr(DSC_OFF_MAIN_CFG, cfg);
            `CHK(main_range, cfg[2:0])
            `CHK(main_mux_sel, cfg[6:4])
            `CHK({burnout_en, main_buffered}, cfg[9:8])
            rd(DSC_OFF_MAIN_CFG, d);
            `CHK(d, cfg)
        end
        for (int m = 0; m < 4; m++) begin
            seed = lfsr(seed);
            w = {26'h0, 2'(m), 3'h0, seed[0]};
            wr(DSC_OFF_AUX_CTL, w);
            `CHK(aux_mux_sel, w[5:4])
            `CHK(aux_range_select, w[0])
        end
        $display("test front end done");
        conv(13, 1'b1);
        cfg = cfg ^ 32'h0000_0200;
        conv(16, 1'b0);
        conclude();
    end
endmodule

bind dsc_top dsc_sva u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .main_range(main_range), .main_mux_sel(main_mux_sel),
    .main_buffered(main_buffered), .burnout_en(burnout_en),
    .main_input_chop(main_input_chop), .aux_range_select(aux_range_select),
    .aux_mux_sel(aux_mux_sel), .aux_input_chop(aux_input_chop)
);
